//--- include/wdt_pkg.sv
`default_nettype none
package wdt_pkg;

   // ----------------------------------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [11:0] ADDR_KEYED_WRITE = 12'h000;
   localparam logic [11:0] ADDR_COUNTER = 12'h004;
   localparam logic [11:0] ADDR_CONTROL_STATUS = 12'h008;
   localparam logic [11:0] ADDR_RESET_CONFIG = 12'h00C;
   localparam logic [11:0] ADDR_IRQ_STATUS = 12'h010;
   localparam logic [11:0] ADDR_IRQ_MASK = 12'h014;

   // ----------------------------------------------------------------
   // Keyed write format: key in [31:16], target in [8], data in [7:0]
   // ----------------------------------------------------------------
   localparam int KEY_MSB = 31;
   localparam int KEY_LSB = 16;
   localparam int KEY_TARGET_BIT = 8;
   localparam logic [15:0] KEY_COUNTER = 16'h5A00;
   localparam logic [15:0] KEY_CONTROL_STATUS = 16'hA500;

   // ----------------------------------------------------------------
   // Control/status field positions and reset values
   // ----------------------------------------------------------------
   localparam int CS_OVERFLOW_BIT = 7;
   localparam int CS_MODE_BIT = 6;
   localparam int CS_ENABLE_BIT = 5;
   localparam int CS_CLKSEL_MSB = 2;
   localparam logic [7:0] CS_RESERVED_MASK = 8'h18;
   localparam logic [7:0] COUNTER_RESET = 8'h00;
   localparam logic [7:0] CONTROL_STATUS_RESET = 8'h18;
   localparam logic [7:0] COUNTER_MAX = 8'hFF;

   // Reset-config register: bit 0 chooses internal reset (1) or NMI (0),
   // bit 1 enables the chosen request
   localparam int RC_SELECT_RESET_BIT = 0;
   localparam int RC_REQUEST_ENABLE_BIT = 1;

   // Interrupt status bits
   localparam int IRQ_OVERFLOW_BIT = 0;
   localparam int IRQ_BAD_WRITE_BIT = 1;

   // ----------------------------------------------------------------
   // Prescaler: exponents of the eight clock divisions
   // ----------------------------------------------------------------
   localparam int PRESCALE_WIDTH = 17;
   localparam logic [4:0] DIV_EXP_0 = 5'h01;
   localparam logic [4:0] DIV_EXP_1 = 5'h06;
   localparam logic [4:0] DIV_EXP_2 = 5'h07;
   localparam logic [4:0] DIV_EXP_3 = 5'h09;
   localparam logic [4:0] DIV_EXP_4 = 5'h0B;
   localparam logic [4:0] DIV_EXP_5 = 5'h0D;
   localparam logic [4:0] DIV_EXP_6 = 5'h0F;
   localparam logic [4:0] DIV_EXP_7 = 5'h11;

   // Internal reset request pulse length
   localparam int RESET_PULSE_NS = 20;
   localparam int CLK_PERIOD_NS = 5;
   localparam logic [3:0] RESET_PULSE_CYCLES = 4'((RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

endpackage
`default_nettype wire

//--- include/prescale_if.sv
`timescale 1ns/100ps
`default_nettype none
interface prescale_if;
   logic run;
   logic [2:0] clock_select;
   logic tick;
   modport ctrl (output run, output clock_select, input tick);
   modport pre (input run, input clock_select, output tick);
endinterface
`default_nettype wire

//--- logic/wdt_prescaler.sv
`timescale 1ns/100ps
`default_nettype none
module wdt_prescaler
   import wdt_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic ce_i,
   // Control side
   prescale_if.pre ps
);

   logic [PRESCALE_WIDTH-1:0] div_reg;
   logic [PRESCALE_WIDTH-1:0] div_next;
   logic tick_reg;
   logic tick_next;
   logic [4:0] exp_sel;

   // Division exponent from the clock-select code
   always_comb begin
      unique case (ps.clock_select)
         3'h0: exp_sel = DIV_EXP_0;
         3'h1: exp_sel = DIV_EXP_1;
         3'h2: exp_sel = DIV_EXP_2;
         3'h3: exp_sel = DIV_EXP_3;
         3'h4: exp_sel = DIV_EXP_4;
         3'h5: exp_sel = DIV_EXP_5;
         3'h6: exp_sel = DIV_EXP_6;
         default: exp_sel = DIV_EXP_7;
      endcase
   end

   // Free divider, held at zero while stopped; tick when low bits wrap
   always_comb begin
      div_next = ps.run ? div_reg + 1'b1 : '0;
      tick_next = 1'b0;
      if (ps.run) begin
         tick_next = ((div_next & ((PRESCALE_WIDTH'(1) << exp_sel) - 1'b1)) == '0); // [R8]
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         div_reg <= '0;
         tick_reg <= 1'b0;
      end else if (ce_i) begin
         div_reg <= div_next;
         tick_reg <= tick_next;
      end
   end

   assign ps.tick = tick_reg;

endmodule
`default_nettype wire

//--- logic/watchdog_interval_timer.sv
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// [R1] Eight-bit readable counter, zero at reset
// [R2] Enable counts; clearing enable zeroes counter
// [R3] Wrap from maximum to zero sets overflow
// [R4] Software clears overflow only by read-then-write zero
// [R5] Internal reset request clears overflow flag
// [R6] Bit 6 picks interval or watchdog mode
// [R7] Bits 4 and 3 read one always
// [R8] Clock select picks one of eight divisions
// [R9] Watchdog overflow requests reset, NMI, or nothing
// [R10] Interval mode interrupts on each overflow
// [R11] Protected registers take only special writes
// [R12] Plain writes ignored; keyed word accepted
// [R13] Interval request follows overflow flag
module watchdog_interval_timer
   import wdt_pkg::*;
(
   // Clock, reset, clock enable
   input wire logic CLK_I,
   input wire logic RSTN_I,
   input wire logic CE_I,
   // APB slave
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [11:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   output logic [31:0] PRDATA_O,
   output logic PREADY_O,
   output logic PSLVERR_O,
   // Requests to the system
   output logic INTERVAL_IRQ_O,
   output logic NMI_REQ_O,
   output logic RESET_REQ_O,
   output logic IRQ_O
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   logic [7:0] counter_reg, counter_next;
   logic overflow_reg, overflow_next;
   logic mode_reg, mode_next;
   logic enable_reg, enable_next;
   logic [2:0] clksel_reg, clksel_next;
   logic [1:0] rcfg_reg, rcfg_next;
   logic ovf_seen_reg, ovf_seen_next;
   logic [1:0] irq_status_reg, irq_status_next;
   logic [1:0] irq_mask_reg, irq_mask_next;
   logic [3:0] rst_cnt_reg, rst_cnt_next;
   logic [31:0] prdata_reg, prdata_next;
   logic pready_reg, pready_next;
   logic pslverr_reg, pslverr_next;
   logic ivl_irq_reg, ivl_irq_next;
   logic nmi_reg, nmi_next;
   logic rst_req_reg, rst_req_next;
   logic irq_reg, irq_next;

   logic access, wr, rd, keyed_ok, wrap, internal_reset;
   logic [7:0] cs_view;
   logic [1:0] events;

   prescale_if ps_bus ();

   // ---------------------------------------------------------------
   // Prescaler
   // ---------------------------------------------------------------
   assign ps_bus.run = enable_reg; // [R2]
   assign ps_bus.clock_select = clksel_reg; // [R8]

   wdt_prescaler u_prescaler (
      .clk_i(CLK_I),
      .rstn_i(RSTN_I),
      .ce_i(CE_I),
      .ps(ps_bus)
   );

   // Bus decode, answer in the second access cycle
   assign access = PSEL_I && PENABLE_I && !pready_reg;
   assign wr = access && PWRITE_I;
   assign rd = access && !PWRITE_I;
   assign keyed_ok = (PWDATA_I[KEY_MSB:KEY_LSB] ==
                      (PWDATA_I[KEY_TARGET_BIT] ? KEY_CONTROL_STATUS : KEY_COUNTER));
   assign wrap = enable_reg && ps_bus.tick && (counter_reg == COUNTER_MAX); // [R3]
   assign internal_reset = (rst_cnt_reg == RESET_PULSE_CYCLES) && mode_reg; // [R5]
   assign cs_view = {overflow_reg, mode_reg, enable_reg, 2'b00, clksel_reg}
                    | CS_RESERVED_MASK; // [R7]

   // ---------------------------------------------------------------
   // Timer state next values
   // ---------------------------------------------------------------
   always_comb begin
      counter_next = counter_reg;
      overflow_next = overflow_reg;
      mode_next = mode_reg;
      enable_next = enable_reg;
      clksel_next = clksel_reg;
      rcfg_next = rcfg_reg;
      ovf_seen_next = ovf_seen_reg;
      rst_cnt_next = (rst_cnt_reg != 4'h0) ? rst_cnt_reg - 4'h1 : 4'h0;
      events = 2'b00;
      // Counting first, so that a keyed counter write in the same cycle wins
      if (enable_reg && ps_bus.tick) begin
         counter_next = counter_reg + 8'h01; // [R1]
      end
      // Read of control/status with flag set arms the clear
      if (rd && PADDR_I == ADDR_CONTROL_STATUS && overflow_reg) begin
         ovf_seen_next = 1'b1; // [R4]
      end
      // Keyed writes only; plain writes to protected registers ignored
      if (wr && PADDR_I == ADDR_KEYED_WRITE && keyed_ok) begin // [R11]
         if (PWDATA_I[KEY_TARGET_BIT]) begin
            mode_next = PWDATA_I[CS_MODE_BIT]; // [R6]
            enable_next = PWDATA_I[CS_ENABLE_BIT];
            clksel_next = PWDATA_I[CS_CLKSEL_MSB:0];
            if (!PWDATA_I[CS_OVERFLOW_BIT] && ovf_seen_reg) begin
               overflow_next = 1'b0; // [R4]
               ovf_seen_next = 1'b0;
            end
         end else begin
            counter_next = PWDATA_I[7:0]; // [R1]
         end
      end else if (wr && (PADDR_I == ADDR_COUNTER || PADDR_I == ADDR_CONTROL_STATUS
                          || (PADDR_I == ADDR_KEYED_WRITE))) begin
         events[IRQ_BAD_WRITE_BIT] = 1'b1; // [R12]
      end
      if (wr && PADDR_I == ADDR_RESET_CONFIG) begin
         rcfg_next = PWDATA_I[1:0];
      end
      if (!enable_next) begin
         counter_next = COUNTER_RESET; // [R2]
      end
      // Overflow sets, winning over a clear
      if (wrap) begin
         overflow_next = 1'b1; // [R3]
         events[IRQ_OVERFLOW_BIT] = 1'b1;
         if (mode_reg && rcfg_reg[RC_REQUEST_ENABLE_BIT]
             && rcfg_reg[RC_SELECT_RESET_BIT]) begin
            rst_cnt_next = RESET_PULSE_CYCLES; // [R9]
         end
      end else if (internal_reset) begin
         overflow_next = 1'b0; // [R5]
         ovf_seen_next = 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Bus, interrupt and request next values
   // ---------------------------------------------------------------
   always_comb begin
      irq_status_next = irq_status_reg | events;
      irq_mask_next = irq_mask_reg;
      prdata_next = prdata_reg;
      pready_next = access;
      pslverr_next = 1'b0;
      if (wr && PADDR_I == ADDR_IRQ_STATUS) begin
         irq_status_next = (irq_status_reg & ~PWDATA_I[1:0]) | events;
      end
      if (wr && PADDR_I == ADDR_IRQ_MASK) begin
         irq_mask_next = PWDATA_I[1:0];
      end
      if (rd) begin
         unique case (PADDR_I)
            ADDR_COUNTER: prdata_next = {24'h000000, counter_reg}; // [R1]
            ADDR_CONTROL_STATUS: prdata_next = {24'h000000, cs_view}; // [R7]
            ADDR_RESET_CONFIG: prdata_next = {30'h0, rcfg_reg};
            ADDR_IRQ_STATUS: prdata_next = {30'h0, irq_status_reg};
            ADDR_IRQ_MASK: prdata_next = {30'h0, irq_mask_reg};
            ADDR_KEYED_WRITE: prdata_next = 32'h00000000;
            default: begin
               prdata_next = 32'h00000000;
               pslverr_next = 1'b1;
            end
         endcase
      end else if (wr) begin
         pslverr_next = !(PADDR_I inside {ADDR_KEYED_WRITE, ADDR_COUNTER,
            ADDR_CONTROL_STATUS, ADDR_RESET_CONFIG, ADDR_IRQ_STATUS, ADDR_IRQ_MASK});
      end
      ivl_irq_next = overflow_next && !mode_next; // [R10] [R13]
      nmi_next = overflow_next && mode_next && rcfg_reg[RC_REQUEST_ENABLE_BIT]
                 && !rcfg_reg[RC_SELECT_RESET_BIT]; // [R9]
      rst_req_next = (rst_cnt_next != 4'h0); // [R9]
      irq_next = |(irq_status_next & irq_mask_next);
   end

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   always_ff @(posedge CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         counter_reg <= COUNTER_RESET;
         overflow_reg <= CONTROL_STATUS_RESET[CS_OVERFLOW_BIT];
         mode_reg <= CONTROL_STATUS_RESET[CS_MODE_BIT];
         enable_reg <= CONTROL_STATUS_RESET[CS_ENABLE_BIT];
         clksel_reg <= CONTROL_STATUS_RESET[CS_CLKSEL_MSB:0];
         rcfg_reg <= 2'h0;
         ovf_seen_reg <= 1'b0;
         irq_status_reg <= 2'h0;
         irq_mask_reg <= 2'h0;
         rst_cnt_reg <= 4'h0;
         prdata_reg <= 32'h00000000;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         ivl_irq_reg <= 1'b0;
         nmi_reg <= 1'b0;
         rst_req_reg <= 1'b0;
         irq_reg <= 1'b0;
      end else if (CE_I) begin
         counter_reg <= counter_next;
         overflow_reg <= overflow_next;
         mode_reg <= mode_next;
         enable_reg <= enable_next;
         clksel_reg <= clksel_next;
         rcfg_reg <= rcfg_next;
         ovf_seen_reg <= ovf_seen_next;
         irq_status_reg <= irq_status_next;
         irq_mask_reg <= irq_mask_next;
         rst_cnt_reg <= rst_cnt_next;
         prdata_reg <= prdata_next;
         pready_reg <= pready_next;
         pslverr_reg <= pslverr_next;
         ivl_irq_reg <= ivl_irq_next;
         nmi_reg <= nmi_next;
         rst_req_reg <= rst_req_next;
         irq_reg <= irq_next;
      end
   end

   assign PRDATA_O = prdata_reg;
   assign PREADY_O = pready_reg;
   assign PSLVERR_O = pslverr_reg;
   assign INTERVAL_IRQ_O = ivl_irq_reg;
   assign NMI_REQ_O = nmi_reg;
   assign RESET_REQ_O = rst_req_reg;
   assign IRQ_O = irq_reg;

endmodule
`default_nettype wire

//--- verification/wdt_checker_props.sv
`timescale 1ns/100ps
`default_nettype none
module wdt_checker
   import wdt_pkg::*;
(
   // Clock and reset
   input wire logic CLK_I,
   input wire logic RSTN_I,
   input wire logic CE_I,
   // Bus
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [11:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   input wire logic [31:0] PRDATA_O,
   input wire logic PREADY_O,
   input wire logic PSLVERR_O,
   // Requests
   input wire logic INTERVAL_IRQ_O,
   input wire logic NMI_REQ_O,
   input wire logic RESET_REQ_O,
   input wire logic IRQ_O
);
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   logic mapped;
   default clocking cb @(posedge CLK_I);
   endclocking
   default disable iff (!RSTN_I);
   // Decode of the register map
   assign mapped = PADDR_I inside {ADDR_KEYED_WRITE, ADDR_COUNTER, ADDR_CONTROL_STATUS,
      ADDR_RESET_CONFIG, ADDR_IRQ_STATUS, ADDR_IRQ_MASK};
   // Steps of an access, a reset request and a recent write
   sequence s_access;
      PSEL_I && PENABLE_I && !PREADY_O && CE_I;
   endsequence
   sequence s_pulse;
      RESET_REQ_O [*4] ##1 !RESET_REQ_O;
   endsequence
   sequence s_wrote;
      $past(PSEL_I && PWRITE_I) || $past(PSEL_I && PWRITE_I, 2);
   endsequence
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   property p_answer;
      s_access |=> PREADY_O;
   endproperty
   property p_ready_pulse;
      PREADY_O |=> !PREADY_O;
   endproperty
   property p_slverr;
      PREADY_O |-> (PSLVERR_O == !mapped);
   endproperty
   property p_reserved;
      PREADY_O && !PWRITE_I && PADDR_I == ADDR_CONTROL_STATUS
         |-> PRDATA_O[4:3] == 2'b11 && PRDATA_O[31:8] == 24'h000000;
   endproperty
   property p_pulse;
      $rose(RESET_REQ_O) |-> s_pulse;
   endproperty
   property p_excl;
      RESET_REQ_O |-> !NMI_REQ_O;
   endproperty
   property p_wd_quiet;
      (NMI_REQ_O || RESET_REQ_O) |-> !INTERVAL_IRQ_O;
   endproperty
   property p_fall;
      $fell(INTERVAL_IRQ_O) || $fell(NMI_REQ_O) |-> s_wrote;
   endproperty
   a_answer: assert property (p_answer)
      else $error("access not answered one cycle later");
   a_ready_pulse: assert property (p_ready_pulse)
      else $error("ready held longer than one cycle");
   a_slverr: assert property (p_slverr)
      else $error("error response does not match address decode");
   a_reserved: assert property (p_reserved)
      else $error("reserved control bits not read as one");
   a_pulse: assert property (p_pulse)
      else $error("reset request pulse not four cycles");
   a_excl: assert property (p_excl)
      else $error("reset and nmi requested together");
   a_wd_quiet: assert property (p_wd_quiet)
      else $error("interval request in watchdog mode");
   a_fall: assert property (p_fall)
      else $error("request dropped without a write");
endmodule
bind watchdog_interval_timer wdt_checker u_chk (.CLK_I(CLK_I), .RSTN_I(RSTN_I),
   .CE_I(CE_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I),
   .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O),
   .PSLVERR_O(PSLVERR_O), .INTERVAL_IRQ_O(INTERVAL_IRQ_O), .NMI_REQ_O(NMI_REQ_O),
   .RESET_REQ_O(RESET_REQ_O), .IRQ_O(IRQ_O));
`default_nettype wire

//--- verification/tb_watchdog_interval_timer.sv
`timescale 1ns/100ps
`default_nettype none
module tb_watchdog_interval_timer
   import wdt_pkg::*;
   ;
   logic clk, rstn, ce, psel, pen, pwr, pready, pslverr, iirq, nmi, rreq, irq, lerr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, base;
   int mismatches = 0;
   int checks = 0;
   int cycles = 0;
   int dexp[8] = '{1, 6, 7, 9, 11, 13, 15, 17};
   // ----------------------------------------
   // Design and clock
   // ----------------------------------------
   watchdog_interval_timer u_dut (.CLK_I(clk), .RSTN_I(rstn), .CE_I(ce), .PSEL_I(psel),
      .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
      .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .INTERVAL_IRQ_O(iirq),
      .NMI_REQ_O(nmi), .RESET_REQ_O(rreq), .IRQ_O(irq));
   // Free running clock
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // Hang guard
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 100000) begin
         mismatches++;
         stop_test();
      end
   end
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic stop_test();
      if (mismatches == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // One bus transfer, held until ready is sampled high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rd = prdata;
      lerr = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h00000000);
      check(nm, rd, e);
   endtask
   // Keyed write: target 1 is control/status, 0 is counter
   task automatic kw(input logic t, input logic [7:0] d);
      apb(1'b1, ADDR_KEYED_WRITE, {t ? KEY_CONTROL_STATUS : KEY_COUNTER, 7'h00, t, d});
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      int n;
      {rstn, psel, pen, pwr, lerr} = 5'h00;
      ce = 1'b1;
      paddr = 12'h000;
      pwdata = 32'h00000000;
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      rdc("counter", ADDR_COUNTER, 32'h00000000);
      rdc("ctl", ADDR_CONTROL_STATUS, 32'h00000018);
      apb(1'b0, 12'h018, 32'h00000000);
      check("slverr", lerr, 1'b1);
      apb(1'b1, ADDR_CONTROL_STATUS, 32'h00000060);
      apb(1'b1, ADDR_KEYED_WRITE, 32'h12340160);
      rdc("plain", ADDR_CONTROL_STATUS, 32'h00000018);
      rdc("refused", ADDR_IRQ_STATUS, 32'h00000002);
      apb(1'b1, ADDR_IRQ_MASK, 32'h00000003);
      check("irq", irq, 1'b1);
      apb(1'b1, ADDR_IRQ_STATUS, 32'h00000002);
      check("irqclr", irq, 1'b0);
      kw(1'b1, 8'h07);
      rdc("rsv", ADDR_CONTROL_STATUS, 32'h0000001F);
      kw(1'b1, 8'h20);
      kw(1'b0, 8'hF0);
      for (n = 0; n < 200 && iirq !== 1'b1; n++) @(posedge clk);
      check("ivl", iirq, 1'b1);
      kw(1'b1, 8'hA0);
      kw(1'b1, 8'h20);
      rdc("noclr", ADDR_CONTROL_STATUS, 32'h000000B8);
      check("ivlhold", iirq, 1'b1);
      kw(1'b1, 8'h20);
      rdc("clr", ADDR_CONTROL_STATUS, 32'h00000038);
      check("ivlclr", iirq, 1'b0);
      rdc("event", ADDR_IRQ_STATUS, 32'h00000001);
      // Clock enable low freezes the count: four live edges give two steps
      apb(1'b0, ADDR_COUNTER, 32'h00000000);
      base = rd;
      ce <= 1'b0;
      repeat (20) @(posedge clk);
      ce <= 1'b1;
      rdc("freeze", ADDR_COUNTER, base + 32'h00000002);
      kw(1'b1, 8'h00);
      rdc("stop", ADDR_COUNTER, 32'h00000000);
      // Each clock division: selects 1 to 5 one step after 1.5 periods, select 0 one to five steps; after 32832 cycles select 6 one step, 7 none
      for (int c = 0; c < 8; c++) begin
         kw(1'b1, 8'h00);
         kw(1'b1, 8'h20 | 8'(c));
         repeat ((c < 6) ? 3 << (dexp[c] - 1) : 32832) @(posedge clk);
         apb(1'b0, ADDR_COUNTER, 32'h00000000);
         if (c == 0)
            check("sel0", rd >= 1 && rd <= 5, 1'b1);
         else
            check("sel", rd, (c == 7) ? 32'h0 : 32'h1);
      end
      kw(1'b1, 8'h00);
      apb(1'b1, ADDR_RESET_CONFIG, 32'h00000002);
      kw(1'b1, 8'h60);
      kw(1'b0, 8'hF0);
      for (n = 0; n < 200 && nmi !== 1'b1; n++) @(posedge clk);
      check("nmi", nmi, 1'b1);
      check("wdivl", iirq, 1'b0);
      rdc("wdflag", ADDR_CONTROL_STATUS, 32'h000000F8);
      kw(1'b1, 8'h60);
      check("nmiclr", nmi, 1'b0);
      apb(1'b1, ADDR_RESET_CONFIG, 32'h00000000);
      kw(1'b0, 8'hF0);
      repeat (60) @(posedge clk);
      check("none", {nmi, rreq}, 2'b00);
      rdc("noreq", ADDR_CONTROL_STATUS, 32'h000000F8);
      kw(1'b1, 8'h60);
      apb(1'b1, ADDR_RESET_CONFIG, 32'h00000003);
      kw(1'b0, 8'hF0);
      for (n = 0; n < 200 && rreq !== 1'b1; n++) @(posedge clk);
      check("rst", rreq, 1'b1);
      repeat (8) @(posedge clk);
      rdc("auto", ADDR_CONTROL_STATUS, 32'h00000078);
      stop_test();
   end
endmodule
`default_nettype wire
